// ---- dv/rssd_ctrl_model.sv ----
`timescale 1ns/100ps
// controller stand-in: heartbeat stops on hang, resumes on a restart while recover is high
module rssd_ctrl_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // scenario control
  input wire logic hang,
  input wire logic recover,
  // supervision pins
  input wire logic ctrl_restart,
  output logic heartbeat_pin,
  output logic restart_ok_pin
);
  logic [2:0] cnt_q;
  always_ff @(posedge mclk) begin
    if (sys_rst || hang) begin
      restart_ok_pin <= !hang;
    end else if (ctrl_restart && recover) begin
      restart_ok_pin <= 1'b1;
    end
  end
  // slow on purpose: one toggle every eight cycles
  always_ff @(posedge mclk) begin
    cnt_q <= sys_rst ? 3'h0 : cnt_q + 3'h1;
    if (sys_rst) begin
      heartbeat_pin <= 1'b0;
    end else if (restart_ok_pin && cnt_q == 3'h7) begin
      heartbeat_pin <= !heartbeat_pin;
    end
  end
endmodule

// ---- dv/rssd_diag_bench.sv ----
`timescale 1ns/100ps
module rssd_diag_bench;
  import rssd_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, hang = 1'b0, recover = 1'b1;
  logic heartbeat_pin, restart_ok_pin, ctrl_restart, perm_fault;
  logic aux_supply_ok_pin = 1'b1, temp_fault_pin = 1'b0;
  logic group_link_load = 1'b0, panel_reset = 1'b0, rd_req = 1'b0;
  logic [23:0] relay_fault_pin = '0, p;
  logic [4:0] sigout_fault_pin = '0, diag_event_code;
  logic [9:0] int_err_pin = '0;
  logic [7:0] alarm_src_pin = '0;
  logic [15:0] alarm_group_sel = 16'h0001;
  logic [2:0] group_link_sf = 3'h2, alarm_groups;
  logic [86:0] group_out_map = 87'h1;
  logic [28:0] out_request = '0, digital_out;
  logic service_status_output, service_led, panel_fault_msg, rd_valid;
  logic [1:0] rd_sel = 2'h0;
  rssd_event_t diag_event;
  rssd_word_t rd_data;
  int failures = 0, checks_done = 0, cyc = 0, i;
  rssd_diag #(.WDG_CYCLES(50), .RESTART_CYCLES(20)) dut (.*);
  rssd_ctrl_model peer (.*);
  always #25 mclk = ~mclk;
  ////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [1:0] s, input logic [15:0] exp);
    @(posedge mclk);
    rd_sel <= s;
    rd_req <= 1'b1;
    @(posedge mclk);
    rd_req <= 1'b0;
    #1;
    chk(rd_valid, 1);
    chk(rd_data, exp);
  endtask
  task automatic link(input logic [2:0] v);
    @(posedge mclk);
    group_link_sf <= v;
    group_link_load <= 1'b1;
    @(posedge mclk);
    group_link_load <= 1'b0;
    step(5);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test;
    end
  end
  ////////////////////////////////////////
  initial begin
    step(5);
    sys_rst <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      p = k ? 24'h5a3c96 : 24'ha5c369;
      @(posedge mclk);
      relay_fault_pin <= p;
      sigout_fault_pin <= p[4:0];
      int_err_pin <= p[9:0];
      step(5);
      rd(2'h0, {p[8], p[4:0], p[7:0], 2'h0});
      rd(2'h1, {1'b0, p[23:9]});
      rd(2'h2, 16'h0);
      rd(2'h3, {6'h0, p[9:0]});
    end
    $display("test registers done");
    chk(service_status_output, 0);
    link(3'h1);
    chk(service_status_output, 1);
    @(posedge mclk);
    alarm_src_pin <= 8'h01;
    step(5);
    chk(alarm_groups, 3'h3);
    chk(digital_out[0], 1);
    chk(service_status_output, 0);
    alarm_src_pin <= 8'h00;
    int_err_pin <= 10'h008;
    link(3'h2);
    temp_fault_pin <= 1'b1;
    for (i = 0; i < 9 && diag_event !== RSSD_EV_FAULT_ON; i++) step(1);
    chk(diag_event, RSSD_EV_FAULT_ON);
    chk(diag_event_code, 5'h13);
    step(3);
    chk(alarm_groups[2], 1);
    temp_fault_pin <= 1'b0;
    int_err_pin <= 10'h0;
    for (i = 0; i < 9 && diag_event !== RSSD_EV_FAULT_OFF; i++) step(1);
    chk(diag_event, RSSD_EV_FAULT_OFF);
    $display("test groups and events done");
    step(5);
    chk(service_status_output, 1);
    aux_supply_ok_pin <= 1'b0;
    step(5);
    chk(service_status_output, 0);
    aux_supply_ok_pin <= 1'b1;
    out_request <= '1;
    step(5);
    chk(digital_out, 29'h1fffffff);
    int_err_pin <= 10'h001;
    step(5);
    chk(alarm_groups, 3'h2);
    panel_reset <= 1'b1;
    step(1);
    panel_reset <= 1'b0;
    step(1);
    chk(alarm_groups, 3'h0);
    int_err_pin <= 10'h0;
    step(5);
    hang <= 1'b1;
    step(1);
    hang <= 1'b0;
    for (i = 0; i < 90 && ctrl_restart !== 1'b1; i++) step(1);
    chk(ctrl_restart, 1);
    step(60);
    chk({perm_fault, service_status_output}, 2'h1);
    recover <= 1'b0;
    hang <= 1'b1;
    step(1);
    hang <= 1'b0;
    for (i = 0; i < 150 && perm_fault !== 1'b1; i++) step(1);
    step(2);
    chk(perm_fault, 1);
    chk(digital_out, 29'h0);
    chk({service_status_output, service_led, panel_fault_msg}, 3'h3);
    $display("test watchdog done");
    finish_test;
  end
endmodule

// ---- dv/rssd_diag_props.sv ----
`timescale 1ns/100ps
module rssd_diag_props
  import rssd_pkg::*;
#(
  parameter int NUM_OUT = 29
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // watched ports
  input wire logic aux_supply_ok_pin,
  input wire logic ctrl_restart,
  input wire logic perm_fault,
  input wire logic service_status_output,
  input wire logic service_led,
  input wire logic panel_fault_msg,
  input wire logic [NUM_OUT-1:0] digital_out,
  input rssd_event_t diag_event,
  input wire logic [1:0] rd_sel,
  input wire logic rd_req,
  input rssd_word_t rd_data,
  input wire logic rd_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  read_answer_a: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  spare_zero_a: assert property (
    rd_req && rd_sel == 2'h2 |=> rd_data == 16'h0) else $error("spare");
  low_reserved_a: assert property (
    rd_req && rd_sel == 2'h0 |=> rd_data[1:0] == 2'h0) else $error("rsvd");
  perm_block_a: assert property (
    perm_fault [*2] |-> digital_out == '0 && !service_status_output)
    else $error("outputs not blocked");
  perm_show_a: assert property (
    perm_fault [*2] |-> service_led && panel_fault_msg)
    else $error("permanent state not shown");
  perm_stick_a: assert property (perm_fault |=> perm_fault)
    else $error("permanent fault dropped");
  restart_pulse_a: assert property (ctrl_restart |=> !ctrl_restart)
    else $error("restart pulse too long");
  supply_loss_a: assert property (
    !aux_supply_ok_pin [*4] |-> !service_status_output)
    else $error("service output without supply");
  cover property (ctrl_restart);
  cover property (perm_fault);
  cover property (diag_event == RSSD_EV_FAULT_OFF);
endmodule

bind rssd_diag rssd_diag_props #(.NUM_OUT(NUM_OUT)) props_i (
  .mclk, .sys_rst, .aux_supply_ok_pin, .ctrl_restart, .perm_fault,
  .service_status_output, .service_led, .panel_fault_msg, .digital_out,
  .diag_event, .rd_sel, .rd_req, .rd_data, .rd_valid);

// ---- hdl/rssd_diag.sv ----
`timescale 1ns/100ps
`include "rssd_consts.svh"

// Overview of operation
// - watchdog checks controller heartbeat and tries a restart when it stalls
// - failed restart raises the permanent internal fault signal
// - permanent fault blocks all digital outputs and de-energizes service status
// - service status energized only with supply present and fully operational
// - permanent state drops service contact, lights service LED, shows panel fault
// - alarm sources offered to output matrix as one vector
// - each alarm assigned to one of three groups, each group linkable
// - default links only group two to the service status output
// - each group drives a configurable set of outputs via matrix
// - boot and runtime hardware and software checks feed the diagnostics
// - temporary inoperative state sets matrix signal and logs fault-on event
// - clearing temporary state logs a fault-off event
// - front panel reset command clears self-diagnostic state
// - four sixteen bit diagnostic registers readable by remote master
// - low output register: reserved 0-1, relays 1-8, signals 1-5, relay 9
// - high output register: relays 10 to 24 in bits 0 to 14
// - internal error bit 0 voltage fault, bit 1 bus buffer error
// - bit 2 order code, bit 3 option card, bit 4 logic config
// - bits 5-8 arc unit, arc sensor, memory card, arc input errors
// - bit 9 flags low auxiliary supply voltage
// - short fault code of the lowest set internal error bit reported with self-diagnostic events
// - unintended status lights service LED and shows status notification
module rssd_diag
  import rssd_pkg::*;
#(
  parameter int NUM_ALARMS = 8,
  parameter int NUM_OUT = 29,
  parameter int WDG_CYCLES =
    `RSSD_WDG_TIMEOUT_US * `RSSD_CLK_MHZ,
  parameter int RESTART_CYCLES =
    `RSSD_RESTART_US * `RSSD_CLK_MHZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // controller supervision
  input wire logic heartbeat_pin,
  input wire logic restart_ok_pin,
  input wire logic aux_supply_ok_pin,
  output logic ctrl_restart,
  output logic perm_fault,
  // fault sources
  input wire logic [23:0] relay_fault_pin,
  input wire logic [4:0] sigout_fault_pin,
  input wire logic [`RSSD_IE_WIDTH-1:0] int_err_pin,
  input wire logic [NUM_ALARMS-1:0] alarm_src_pin,
  input wire logic temp_fault_pin,
  // configuration
  input wire logic [2*NUM_ALARMS-1:0] alarm_group_sel,
  input wire logic [2:0] group_link_sf,
  input wire logic group_link_load,
  input wire logic [3*NUM_OUT-1:0] group_out_map,
  input wire logic [NUM_OUT-1:0] out_request,
  input wire logic panel_reset,
  // outputs
  output logic service_status_output,
  output logic service_led,
  output logic panel_fault_msg,
  output logic [NUM_OUT-1:0] digital_out,
  output logic [2:0] alarm_groups,
  output rssd_event_t diag_event,
  output logic [4:0] diag_event_code,
  // remote read port
  input wire logic [1:0] rd_sel,
  input wire logic rd_req,
  output rssd_word_t rd_data,
  output logic rd_valid
);
  import rssd_pkg::*;

  initial begin
    if (NUM_ALARMS < 1 || NUM_ALARMS > 16 || NUM_OUT < 1 || WDG_CYCLES < 2
        || RESTART_CYCLES < 2) begin
      $error("rssd_diag: unsupported parameter values");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int SW = 4 + 24 + 5 + `RSSD_IE_WIDTH + NUM_ALARMS;
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {heartbeat_pin, restart_ok_pin, aux_supply_ok_pin,
               temp_fault_pin, relay_fault_pin, sigout_fault_pin,
               int_err_pin, alarm_src_pin};
      s2_q <= s1_q;
    end
  end
  logic hb_s, rok_s, aux_s, temp_s;
  logic [23:0] relay_s;
  logic [4:0] sig_s;
  logic [`RSSD_IE_WIDTH-1:0] ie_s;
  logic [NUM_ALARMS-1:0] alarm_s;
  assign {hb_s, rok_s, aux_s, temp_s, relay_s, sig_s, ie_s, alarm_s} = s2_q;

  //////////////////////////////////////////////////////////////////////////
  // watchdog
  rssd_wdg_t wdg_q;
  logic [31:0] wcnt_q;
  logic hb_prev_q;
  logic hb_edge;
  assign hb_edge = hb_s ^ hb_prev_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wdg_q <= RSSD_RUN;
      wcnt_q <= '0;
      hb_prev_q <= 1'b0;
    end else begin
      hb_prev_q <= hb_s;
      unique case (wdg_q)
        RSSD_RUN: begin
          if (hb_edge) begin
            wcnt_q <= '0;
          end else if (wcnt_q == 32'(WDG_CYCLES - 1)) begin
            wdg_q <= RSSD_RESTART;
            wcnt_q <= '0;
          end else begin
            wcnt_q <= wcnt_q + 32'h1;
          end
        end
        RSSD_RESTART: begin
          wdg_q <= RSSD_WAIT;
        end
        RSSD_WAIT: begin
          if (rok_s && hb_edge) begin
            wdg_q <= RSSD_RUN;
            wcnt_q <= '0;
          end else if (wcnt_q == 32'(RESTART_CYCLES - 1)) begin
            wdg_q <= RSSD_PERM;
          end else begin
            wcnt_q <= wcnt_q + 32'h1;
          end
        end
        RSSD_PERM: begin
          // only a system reset leaves the permanent state
          wdg_q <= RSSD_PERM;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // alarm grouping and configuration
  logic [2:0] link_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      link_q <= `RSSD_GROUP_LINK_RST;
    end else if (group_link_load) begin
      link_q <= group_link_sf;
    end
  end

  logic [NUM_ALARMS-1:0] a_g1, a_g2, a_g3;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ALARMS; gi++) begin : g_alarm
      // code 0 leaves an alarm unassigned
      assign a_g1[gi] = alarm_s[gi] && alarm_group_sel[2*gi +: 2] == 2'h1;
      assign a_g2[gi] = alarm_s[gi] && alarm_group_sel[2*gi +: 2] == 2'h2;
      assign a_g3[gi] = alarm_s[gi] && alarm_group_sel[2*gi +: 2] == 2'h3;
    end
  endgenerate

  // fault flags hold until the source clears or the panel resets them
  rssd_word_t low_q, high_q, ie_q;
  logic [2:0] grp_q;
  logic temp_q;
  logic [2:0] grp_d;
  assign grp_d = {|a_g3 | (temp_s | temp_q), |a_g2 | (|ie_q), |a_g1};
  always_ff @(posedge mclk) begin
    if (sys_rst || panel_reset) begin
      grp_q <= '0;
    end else begin
      grp_q <= grp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // temporary fault events
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      temp_q <= 1'b0;
      diag_event <= RSSD_EV_NONE;
      diag_event_code <= 5'h0;
    end else begin
      temp_q <= temp_s;
      diag_event <= RSSD_EV_NONE;
      if (temp_s && !temp_q) begin
        diag_event <= RSSD_EV_FAULT_ON;
        diag_event_code <= 5'h10 | 5'(first_ie(ie_s));
      end else if (!temp_s && temp_q) begin
        diag_event <= RSSD_EV_FAULT_OFF;
        diag_event_code <= 5'h10 | 5'(first_ie(ie_s));
      end
    end
  end

  function automatic logic [3:0] first_ie(logic [`RSSD_IE_WIDTH-1:0] v);
    logic [3:0] r;
    r = 4'hf;
    for (int i = `RSSD_IE_WIDTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // diagnostic registers
  rssd_word_t low_d, high_d, ie_d;
  always_comb begin
    low_d = '0;
    low_d[`RSSD_LOW_RELAY_LSB +: 8] = relay_s[7:0];
    low_d[`RSSD_LOW_SIG_LSB +: 5] = sig_s;
    low_d[`RSSD_LOW_RELAY9_BIT] = relay_s[8];
    high_d = '0;
    high_d[14:0] = relay_s[23:9];
    ie_d = '0;
    ie_d[`RSSD_IE_VOLT] = ie_s[`RSSD_IE_VOLT];
    ie_d[`RSSD_IE_BUSBUF] = ie_s[`RSSD_IE_BUSBUF];
    ie_d[`RSSD_IE_PLCONF:`RSSD_IE_ORDER] =
      ie_s[`RSSD_IE_PLCONF:`RSSD_IE_ORDER];
    ie_d[`RSSD_IE_ARCBI:`RSSD_IE_ARCIO] =
      ie_s[`RSSD_IE_ARCBI:`RSSD_IE_ARCIO];
    ie_d[`RSSD_IE_LOWSUP] = ie_s[`RSSD_IE_LOWSUP] | ~aux_s;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || panel_reset) begin
      low_q <= '0;
      high_q <= '0;
      ie_q <= '0;
    end else begin
      // a source still active sets its flag again in the cycle after the panel reset
      low_q <= low_d;
      high_q <= high_d;
      ie_q <= ie_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        unique case (rd_sel)
          `RSSD_SEL_OUT_LOW: rd_data <= low_q;
          `RSSD_SEL_OUT_HIGH: rd_data <= high_q;
          `RSSD_SEL_SPARE: rd_data <= '0;
          `RSSD_SEL_INT_ERR: rd_data <= ie_q;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  logic perm;
  logic [NUM_OUT-1:0] matrix;
  assign perm = (wdg_q == RSSD_PERM);
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      assign matrix[gi] = |(group_out_map[3*gi +: 3] & grp_q);
    end
  endgenerate
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      service_status_output <= 1'b0;
      service_led <= 1'b0;
      panel_fault_msg <= 1'b0;
      digital_out <= '0;
      alarm_groups <= '0;
      ctrl_restart <= 1'b0;
      perm_fault <= 1'b0;
    end else begin
      ctrl_restart <= (wdg_q == RSSD_RESTART);
      perm_fault <= perm;
      alarm_groups <= grp_q;
      // de-energized on loss of supply or a linked alarm: fail-safe
      service_status_output <= aux_s && !perm && wdg_q == RSSD_RUN
                               && !(|(grp_q & link_q));
      service_led <= perm || (|grp_q);
      panel_fault_msg <= perm || (|grp_q);
      digital_out <= perm ? '0 : (out_request | matrix);
    end
  end
endmodule

// ---- pkg/rssd_consts.svh ----
`ifndef RSSD_CONSTS_SVH
`define RSSD_CONSTS_SVH
// register select codes on the remote read port
`define RSSD_SEL_OUT_LOW 2'h0
`define RSSD_SEL_OUT_HIGH 2'h1
`define RSSD_SEL_SPARE 2'h2
`define RSSD_SEL_INT_ERR 2'h3
// field positions in the output fault flags low register
`define RSSD_LOW_RELAY_LSB 2
`define RSSD_LOW_SIG_LSB 10
`define RSSD_LOW_RELAY9_BIT 15
// internal error flag positions
`define RSSD_IE_VOLT 0
`define RSSD_IE_BUSBUF 1
`define RSSD_IE_ORDER 2
`define RSSD_IE_CARD 3
`define RSSD_IE_PLCONF 4
`define RSSD_IE_ARCIO 5
`define RSSD_IE_ARCSENS 6
`define RSSD_IE_MEMCARD 7
`define RSSD_IE_ARCBI 8
`define RSSD_IE_LOWSUP 9
`define RSSD_IE_WIDTH 10
// link reset value, default timeouts and clock rate
`define RSSD_GROUP_LINK_RST 3'h2
`define RSSD_WDG_TIMEOUT_US 1000
`define RSSD_RESTART_US 500
`define RSSD_CLK_MHZ 20
`endif

// ---- pkg/rssd_pkg.sv ----
package rssd_pkg;
  typedef enum logic [1:0] {
    RSSD_RUN,
    RSSD_RESTART,
    RSSD_WAIT,
    RSSD_PERM
  } rssd_wdg_t;
  typedef logic [15:0] rssd_word_t;
  typedef logic [2:0] rssd_grp_t;
  // self-diagnostic event codes, arbitrary local encoding
  typedef enum logic [1:0] {
    RSSD_EV_NONE,
    RSSD_EV_FAULT_ON,
    RSSD_EV_FAULT_OFF
  } rssd_event_t;
endpackage
